// *** src/gspc_pkg.sv ***
// Constants shared by the whole-array sector protection controller.
package gspc_pkg;
  // Serial command opcodes.
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PROT = 8'h36;
  localparam logic [7:0] OP_UNPROT = 8'h39;
  // Least byte counts of each command frame.
  localparam logic [2:0] LEN_WREN = 3'h1;
  localparam logic [2:0] LEN_WRSR = 3'h2;
  localparam logic [2:0] LEN_SECT = 3'h4;
  // Status data field positions and global patterns.
  localparam int GLB_LSB = 2;
  localparam int GLB_MSB = 5;
  localparam int LOCK_POS = 7;
  localparam logic [3:0] GLB_ALL_SET = 4'hF;
  localparam logic [3:0] GLB_ALL_CLR = 4'h0;
  // Sector address field inside the first address byte.
  localparam int SECT_LSB = 0;
  localparam int SECT_MSB = 4;
  // Register byte offsets.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_SECT = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  // Status register field positions.
  localparam int ST_LATCH = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_WP = 2;
  // Control register field positions.
  localparam int CTRL_RST = 0;
  // Reset values.
  localparam logic SECT_RST_VAL = 1'b1;
  localparam logic LATCH_RST_VAL = 1'b0;
  localparam logic LOCK_RST_VAL = 1'b0;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Write channel states.
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } gspc_wr_t;
endpackage : gspc_pkg

// *** src/gspc_sync.sv ***
// Two-flop synchroniser for levels entering the bus clock domain.
`timescale 1ns/1ns
module gspc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  // The reset value is all ones so that idle-high pins do not look like edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '1;
      hold_ff <= '1;
    end else begin
      meta_ff <= d;
      hold_ff <= meta_ff;
    end
  end

  assign q = hold_ff;
endmodule : gspc_sync

// *** src/gspc_ctrl.sv ***
// Whole-array sector protection controller with serial front end and register bus.
//
// How it works
// - Whole-array protect or unprotect happens only as a side effect of a status write.
// - The same status write also updates the protection_lock_bit.
// - A permitted status write with ones in bits five to two protects every sector.
// - A permitted status write with zeros in bits five to two unprotects every sector.
// - Data 0x0000xx unprotects all sectors and leaves the protection_lock_bit at zero.
// - Single sector protect and unprotect commands keep working after a global operation.
// - A mixed pattern in bits five to two leaves every sector bit unchanged.
// - Without the write_latch_bit set a status write and its side effects do not execute.
// - Every sector protection bit comes up as one after reset or a device reset.
// - While locked, sector commands are ignored and the write_latch_bit is cleared.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module gspc_ctrl #(
  parameter int SECTORS = 32
) (
  // Bus clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  // AXI4-Lite write address and data.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  // Link domain capture. The chip select rise before a frame starts that frame, since sclk
  // stops outside frames; captured values hold still after chip select rises.
  logic first_ff;
  logic [2:0] bit_ff;
  logic [2:0] byte_ff;
  logic [6:0] shift_ff;
  logic [7:0] opcode_ff;
  logic [7:0] byte1_ff;
  logic [2:0] cur_bit;
  logic [2:0] cur_byte;
  wire [7:0] rx_byte = {shift_ff, mosi};
  wire byte_done = (cur_bit == 3'h7);

  assign cur_bit = first_ff ? 3'h0 : bit_ff;
  assign cur_byte = first_ff ? 3'h0 : byte_ff;

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  always_ff @(posedge sclk) begin
    shift_ff <= rx_byte[6:0];
    bit_ff <= cur_bit + 3'h1;
    if (byte_done && cur_byte != 3'h7) begin
      byte_ff <= cur_byte + 3'h1;
    end else begin
      byte_ff <= cur_byte;
    end
    if (byte_done && cur_byte == 3'h0) begin
      opcode_ff <= rx_byte;
    end
    if (byte_done && cur_byte == 3'h1) begin
      byte1_ff <= rx_byte;
    end
  end

  // Bus domain side of the crossing.
  logic cs_s;
  logic wp_s;
  logic cs_prev_ff;
  gspc_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({cs_n, wp_n}),
    .q({cs_s, wp_s})
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_prev_ff <= 1'b1;
    end else begin
      cs_prev_ff <= cs_s;
    end
  end

  // Command decode on the end of each frame.
  logic latch_ff;
  logic lock_ff;
  logic [SECTORS-1:0] sect_ff;
  logic dev_rst;
  wire frame_end = cs_s && !cs_prev_ff;
  wire on_byte = (bit_ff == 3'h0);
  wire is_wren = frame_end && opcode_ff == gspc_pkg::OP_WREN && on_byte
    && byte_ff >= gspc_pkg::LEN_WREN;
  wire is_wrdi = frame_end && opcode_ff == gspc_pkg::OP_WRDI && on_byte
    && byte_ff >= gspc_pkg::LEN_WREN;
  wire is_wrsr = frame_end && opcode_ff == gspc_pkg::OP_WRSR && on_byte
    && byte_ff >= gspc_pkg::LEN_WRSR;
  wire is_sect = frame_end && latch_ff
    && (opcode_ff == gspc_pkg::OP_PROT || opcode_ff == gspc_pkg::OP_UNPROT);
  wire sect_ok = is_sect && on_byte && byte_ff >= gspc_pkg::LEN_SECT && !lock_ff;
  wire wrsr_exec = is_wrsr && latch_ff;
  // Locked with the pin low forbids any change; otherwise the lock bit may change.
  wire lock_ok = wrsr_exec && (!lock_ff || wp_s);
  // On a status write the sector bits themselves change only while currently unlocked.
  wire glb_ok = wrsr_exec && !lock_ff;
  wire [3:0] glb_field = byte1_ff[gspc_pkg::GLB_MSB:gspc_pkg::GLB_LSB];
  wire glb_set = glb_ok && glb_field == gspc_pkg::GLB_ALL_SET;
  wire glb_clr = glb_ok && glb_field == gspc_pkg::GLB_ALL_CLR;
  wire [4:0] sect_idx = byte1_ff[gspc_pkg::SECT_MSB:gspc_pkg::SECT_LSB];

  always_ff @(posedge aclk) begin
    if (!aresetn || dev_rst) begin
      latch_ff <= gspc_pkg::LATCH_RST_VAL;
      lock_ff <= gspc_pkg::LOCK_RST_VAL;
    end else begin
      if (is_wren) begin
        latch_ff <= 1'b1;
      end else if (is_wrdi || wrsr_exec || is_sect) begin
        latch_ff <= 1'b0;
      end
      if (lock_ok) begin
        lock_ff <= byte1_ff[gspc_pkg::LOCK_POS];
      end
    end
  end

  // Sector bits: global ops apply to all, single commands to the addressed one.
  for (genvar i = 0; i < SECTORS; i++) begin : g_sect
    wire hit = sect_ok && sect_idx == 5'(i);
    always_ff @(posedge aclk) begin
      if (!aresetn || dev_rst) begin
        sect_ff[i] <= gspc_pkg::SECT_RST_VAL;
      end else if (glb_set) begin
        sect_ff[i] <= 1'b1;
      end else if (glb_clr) begin
        sect_ff[i] <= 1'b0;
      end else if (hit) begin
        sect_ff[i] <= (opcode_ff == gspc_pkg::OP_PROT);
      end
    end
  end

  // AXI4-Lite slave. Address and data are taken in either order, then answered.
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic strb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  gspc_pkg::gspc_wr_t wr_state_ff;
  gspc_pkg::gspc_wr_t nxt_wr_state;
  wire wr_idle = (wr_state_ff == gspc_pkg::WR_IDLE);
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = wr_idle && aw_got_ff && w_got_ff;
  wire wr_ctrl = awaddr_ff == gspc_pkg::OFF_CTRL;
  wire wr_known = wr_ctrl || awaddr_ff == gspc_pkg::OFF_STATUS
    || awaddr_ff == gspc_pkg::OFF_SECT;
  wire [31:0] status_word = {29'h0, wp_s, lock_ff, latch_ff};
  wire rd_known = s_axi_araddr == gspc_pkg::OFF_STATUS
    || s_axi_araddr == gspc_pkg::OFF_SECT || s_axi_araddr == gspc_pkg::OFF_CTRL;
  wire [31:0] rd_word = (s_axi_araddr == gspc_pkg::OFF_SECT) ? 32'(sect_ff)
    : (s_axi_araddr == gspc_pkg::OFF_STATUS) ? status_word : 32'h0;

  // A device reset requested by software re-protects the array in one cycle.
  // The strobe is kept with the data, since the master may move on once W is taken.
  assign dev_rst = wr_fire && wr_ctrl && strb0_ff && wdata_ff[gspc_pkg::CTRL_RST];
  assign s_axi_awready = wr_idle && !aw_got_ff;
  assign s_axi_wready = wr_idle && !w_got_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_comb begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      gspc_pkg::WR_IDLE: begin
        if (aw_got_ff && w_got_ff) begin
          nxt_wr_state = gspc_pkg::WR_RESP;
        end
      end
      gspc_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_state = gspc_pkg::WR_IDLE;
        end
      end
      default: begin
        nxt_wr_state = gspc_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= gspc_pkg::WR_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      strb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= gspc_pkg::RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      if (aw_take) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end
      if (w_take) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        strb0_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? gspc_pkg::RESP_OKAY : gspc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= gspc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_known ? gspc_pkg::RESP_OKAY : gspc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Checks kept beside the logic they guard.
  only_wrsr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !wrsr_exec && !sect_ok && !dev_rst |=> $stable(sect_ff))
    else $error("Sector bits changed without a command.");
  lock_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_ok && !dev_rst |=> lock_ff == $past(byte1_ff[7]))
    else $error("Lock bit not taken from status data.");
  glb_protect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    glb_ok && byte1_ff[5:2] == 4'hF |=> &sect_ff)
    else $error("Global protect left a sector open.");
  glb_unprot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    glb_ok && byte1_ff[5:2] == 4'h0 && !dev_rst |=> sect_ff == '0)
    else $error("Global unprotect left a sector protected.");
  zero_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    glb_ok && byte1_ff[7] == 1'b0 && byte1_ff[5:2] == 4'h0 && !dev_rst
    |=> !lock_ff && sect_ff == '0)
    else $error("Zero status write did not unprotect and unlock.");
  single_sect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sect_ok && !dev_rst |=> sect_ff[$past(sect_idx)] == ($past(opcode_ff) == 8'h36))
    else $error("Single sector command had no effect.");
  mixed_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wrsr_exec && byte1_ff[5:2] != 4'hF && byte1_ff[5:2] != 4'h0 && !dev_rst
    |=> $stable(sect_ff))
    else $error("Mixed pattern changed sector bits.");
  no_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_wrsr && !latch_ff && !dev_rst |=> $stable(sect_ff) && $stable(lock_ff))
    else $error("Status write ran without the write latch.");
  dev_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_rst |=> &sect_ff && !latch_ff && !lock_ff)
    else $error("Device reset did not protect all sectors.");
  locked_ign_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_sect && lock_ff && !dev_rst |=> $stable(sect_ff) && !latch_ff)
    else $error("Locked sector command was not ignored.");
endmodule : gspc_ctrl

// *** test/gspc_host.sv ***
// Serial host model that sends command frames to the protection controller.
`timescale 1ns/1ns
module gspc_host (
  // Serial link.
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // One rising chip select before any frame puts the link capture in a known state.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    #1 cs_n = 1'b1;
  end
  // Sends the top nbits of w, MSB first; the clock stands still outside frames.
  task automatic frame(input logic [31:0] w, input int nbits);
    #3 cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = w[31-i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    // A released line must not keep its last value, so show the inverse.
    mosi = ~mosi;
    #100;
  endtask : frame
endmodule : gspc_host

// *** test/testbench.sv ***
// Self-checking bench for the whole-array sector protection controller.
`timescale 1ns/1ns
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end \
end
module testbench;
  logic aclk, aresetn, wp_n, sclk, cs_n, mosi;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] rexp;
  logic [1:0] bexp;
  logic [4:0] k;
  int num_errors = 0;
  int n_tests = 0;

  gspc_ctrl #(.SECTORS(32)) dut (.aclk(aclk), .aresetn(aresetn), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .wp_n(wp_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  gspc_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Each transfer shows exactly one falling edge with valid and ready both high.
  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      rexp = rq.pop_front();
      `CHK({rresp, rdata}, rexp)
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      bexp = bq.pop_front();
      `CHK(bresp, bexp)
    end
  end

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, pa, pw;
    bq.push_back(e);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    // Pending flags are kept locally, since the valid signals still hold old values here.
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready === 1'b1;
      tw = pw && wready === 1'b1;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic wren;
    host.frame({gspc_pkg::OP_WREN, 24'h000000}, 8);
  endtask : wren

  task automatic wrsr(input logic [7:0] d);
    wren();
    host.frame({gspc_pkg::OP_WRSR, d, 16'h0000}, 16);
  endtask : wrsr

  task automatic sect(input logic [7:0] op, input logic [4:0] s);
    wren();
    host.frame({op, 3'h0, s, 16'h0000}, 32);
  endtask : sect

  task automatic sr(input logic [31:0] st, input logic [31:0] sp);
    rd(gspc_pkg::OFF_STATUS, {gspc_pkg::RESP_OKAY, st});
    rd(gspc_pkg::OFF_SECT, {gspc_pkg::RESP_OKAY, sp});
  endtask : sr

  task automatic print_verdict;
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wp_n = 1'b1;
    aresetn = 1'b0;
    void'($urandom(49369));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    sr(32'h00000004, 32'hFFFFFFFF);
    host.frame({gspc_pkg::OP_WRSR, 8'h00, 16'h0000}, 16);
    sr(32'h00000004, 32'hFFFFFFFF);
    wren();
    sr(32'h00000005, 32'hFFFFFFFF);
    host.frame({gspc_pkg::OP_WRDI, 24'h000000}, 8);
    sr(32'h00000004, 32'hFFFFFFFF);
    k = 5'($urandom_range(31));
    wrsr({1'b0, k[0], 4'h0, k[2:1]});
    sr(32'h00000004, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wrsr({1'b0, k[i], 4'($urandom_range(14, 1)), 2'($urandom)});
      sr(32'h00000004, 32'h00000000);
    end
    wrsr(8'h3C);
    sr(32'h00000004, 32'hFFFFFFFF);
    wrsr(8'h43);
    sr(32'h00000004, 32'h00000000);
    wrsr(8'h3C);
    sect(gspc_pkg::OP_UNPROT, k);
    sr(32'h00000004, ~(32'h1 << k));
    sect(gspc_pkg::OP_PROT, k);
    sr(32'h00000004, 32'hFFFFFFFF);
    wrsr(8'hBC);
    sr(32'h00000006, 32'hFFFFFFFF);
    sect(gspc_pkg::OP_UNPROT, k);
    sr(32'h00000006, 32'hFFFFFFFF);
    wp_n <= 1'b0;
    repeat (4) @(posedge aclk);
    wrsr(8'h00);
    sr(32'h00000002, 32'hFFFFFFFF);
    wp_n <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(gspc_pkg::OFF_CTRL, 32'h00000001, gspc_pkg::RESP_OKAY);
    sr(32'h00000004, 32'hFFFFFFFF);
    sect(gspc_pkg::OP_UNPROT, k);
    wr(gspc_pkg::OFF_CTRL, 32'h00000001, gspc_pkg::RESP_OKAY);
    sr(32'h00000004, 32'hFFFFFFFF);
    wr(gspc_pkg::OFF_SECT, 32'h00000000, gspc_pkg::RESP_OKAY);
    sr(32'h00000004, 32'hFFFFFFFF);
    rd(gspc_pkg::OFF_CTRL, {gspc_pkg::RESP_OKAY, 32'h00000000});
    wr(8'h0C, 32'hFFFFFFFF, gspc_pkg::RESP_SLVERR);
    rd(8'h0C, {gspc_pkg::RESP_SLVERR, 32'h00000000});
    print_verdict();
  end
endmodule : testbench
